// ### core/stsum_defines.svh
// Purpose: offsets, field positions, reset values of the status module
// Assumes: byte addresses on the register port, base plus offset
// Notes: offsets are stored exactly as printed, several are not word aligned
`ifndef STSUM_DEFINES_SVH
`define STSUM_DEFINES_SVH

`define STSUM_ADDR_W        12
`define STSUM_BASE          12'h280
`define STSUM_OFS_SIG       12'h000
`define STSUM_OFS_DEV       12'h004
`define STSUM_OFS_IRQ_STAT  12'h030
`define STSUM_OFS_IRQ_MASK  12'h034

`define STSUM_SIG_RESET     32'h00000000
`define STSUM_DEV_INT_BIT   25
`define STSUM_DEV_FAULT_BIT 24
`define STSUM_DEV_RSV_MSB   31
`define STSUM_DEV_RSV_LSB   26
`define STSUM_DEV_BOOT_BIT  18
`define STSUM_DEV_READY_BIT 7
`define STSUM_DEV_MISC_W    24

`define STSUM_EVENT_W       32
`define STSUM_IRQ_W         5
`define STSUM_IRQ_SIG       0
`define STSUM_IRQ_BOOT      1
`define STSUM_IRQ_READY     2
`define STSUM_IRQ_INT       3
`define STSUM_IRQ_FAULT     4
`define STSUM_IRQ_RESET     5'h00

`define STSUM_AUX_COUNT     18
`define STSUM_OFS_STARTUP   12'h008
`define STSUM_OFS_SERCRC    12'h00B
`define STSUM_OFS_PIN       12'h00C
`define STSUM_OFS_BIAS      12'h00E
`define STSUM_OFS_PLL       12'h010
`define STSUM_OFS_OSCCAL    12'h011
`define STSUM_OFS_OSCTRIM   12'h012
`define STSUM_OFS_SPARE     12'h014
`define STSUM_OFS_LOSMON    12'h016
`define STSUM_OFS_PPMMON    12'h017
`define STSUM_OFS_FREQMON   12'h018
`define STSUM_OFS_OTPSTS    12'h01C
`define STSUM_OFS_OTPERR    12'h01D
`define STSUM_OFS_OTPPAR    12'h01E
`define STSUM_OFS_DPOST     12'h020
`define STSUM_OFS_APOST     12'h024
`define STSUM_OFS_DPOSTFSM  12'h028
`define STSUM_OFS_APOSTFSM  12'h02A

`define STSUM_MASK_8        32'h000000FF
`define STSUM_MASK_16       32'h0000FFFF
`define STSUM_MASK_24       32'h00FFFFFF
`define STSUM_MASK_32       32'hFFFFFFFF

`endif

// ### core/stsum_pkg.sv
// Purpose: shared types of the status summary block
// Assumes: constants live in stsum_defines.svh
// Notes: none
package stsum_pkg;
	typedef logic [31:0] stsum_word_type;
	typedef logic [4:0]  stsum_aux_idx_type;
	typedef enum {
		STSUM_SEL_SIG,
		STSUM_SEL_DEV,
		STSUM_SEL_AUX,
		STSUM_SEL_IRQ_STAT,
		STSUM_SEL_IRQ_MASK,
		STSUM_SEL_NONE
	} stsum_sel_type;
endpackage : stsum_pkg

// ### core/stsum_gate.sv
// Purpose: one masked summary bit, OR of enabled events behind a global gate
// Assumes: events and enables synchronous to clk_sys_in
// Notes: registered, so the summary lags its cause by one clock
`timescale 1ns/1ns
`include "stsum_defines.svh"
module stsum_gate (
	input  wire logic                      clk_sys_in,
	input  wire logic                      reset_n_in,
	input  wire logic [`STSUM_EVENT_W-1:0] event_in,
	input  wire logic [`STSUM_EVENT_W-1:0] enable_in,
	input  wire logic                      global_en_in,
	output logic                           summary_out
);
	wire next_summary;

	assign next_summary = global_en_in & (|(event_in & enable_in));

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			summary_out <= 1'b0;
		end else begin
			summary_out <= next_summary;
		end
	end
endmodule : stsum_gate

// ### core/stsum_regs.sv
// Purpose: status register module with interrupt and fault summary bits
// Assumes: single clock, plain register port, read data one cycle later
// Notes: all status fields are read only; only the irq mask is writable
`timescale 1ns/1ns
`include "stsum_defines.svh"
module stsum_regs (
	input  wire logic                        clk_sys_in,
	input  wire logic                        reset_n_in,
	input  wire logic [`STSUM_ADDR_W-1:0]    addr_in,
	input  wire logic [31:0]                 wdata_in,
	input  wire logic                        wr_in,
	input  wire logic                        rd_in,
	output logic      [31:0]                 rdata_out,
	input  wire logic                        sig_check_done_in,
	input  wire logic [31:0]                 sig_crc_in,
	input  wire logic [`STSUM_EVENT_W-1:0]   event_in,
	input  wire logic [`STSUM_EVENT_W-1:0]   int_en_in,
	input  wire logic [`STSUM_EVENT_W-1:0]   fault_en_in,
	input  wire logic                        int_global_en_in,
	input  wire logic                        fault_global_en_in,
	input  wire logic                        boot_done_in,
	input  wire logic                        otp_load_done_in,
	input  wire logic [`STSUM_DEV_MISC_W-1:0] dev_misc_in,
	input  wire logic [31:0]                 aux_status_in [`STSUM_AUX_COUNT],
	output logic                             gpio_int_out,
	output logic                             gpio_fault_out,
	output logic                             safe_state_out,
	output logic                             irq_out
);
	logic [31:0]              sig_result;
	logic                     boot_done;
	logic                     device_ready;
	logic [`STSUM_IRQ_W-1:0]  irq_stat;
	logic [`STSUM_IRQ_W-1:0]  irq_mask;
	logic                     int_prev;
	logic                     fault_prev;
	wire                      int_summary;
	wire                      fault_summary;
	wire  [31:0]              dev_word;
	wire  [31:0]              aux_masked [`STSUM_AUX_COUNT];
	stsum_pkg::stsum_sel_type sel;
	wire  [4:0]               aux_idx;
	wire  [31:0]              next_rdata;
	wire                      rd_irq_stat;
	wire                      wr_irq_mask;
	wire  [`STSUM_IRQ_W-1:0]  irq_events;
	wire  [`STSUM_IRQ_W-1:0]  next_irq_stat;

	// offset relative to the module base; out-of-module addresses decode none
	function automatic stsum_pkg::stsum_sel_type decode_sel(
		input logic [`STSUM_ADDR_W-1:0] a);
		logic [`STSUM_ADDR_W-1:0] ofs;
		ofs = a - `STSUM_BASE;
		if (a < `STSUM_BASE) begin
			decode_sel = stsum_pkg::STSUM_SEL_NONE;
		end else begin
			case (ofs)
				`STSUM_OFS_SIG:      decode_sel = stsum_pkg::STSUM_SEL_SIG;
				`STSUM_OFS_DEV:      decode_sel = stsum_pkg::STSUM_SEL_DEV;
				`STSUM_OFS_IRQ_STAT: decode_sel = stsum_pkg::STSUM_SEL_IRQ_STAT;
				`STSUM_OFS_IRQ_MASK: decode_sel = stsum_pkg::STSUM_SEL_IRQ_MASK;
				default: begin
					if (aux_index(a) != 5'h1F) begin
						decode_sel = stsum_pkg::STSUM_SEL_AUX;
					end else begin
						decode_sel = stsum_pkg::STSUM_SEL_NONE;
					end
				end
			endcase
		end
	endfunction : decode_sel

	// index of the wider status registers; 5'h1F marks no match
	function automatic logic [4:0] aux_index(
		input logic [`STSUM_ADDR_W-1:0] a);
		case (a - `STSUM_BASE)
			`STSUM_OFS_STARTUP:  aux_index = 5'h00;
			`STSUM_OFS_SERCRC:   aux_index = 5'h01;
			`STSUM_OFS_PIN:      aux_index = 5'h02;
			`STSUM_OFS_BIAS:     aux_index = 5'h03;
			`STSUM_OFS_PLL:      aux_index = 5'h04;
			`STSUM_OFS_OSCCAL:   aux_index = 5'h05;
			`STSUM_OFS_OSCTRIM:  aux_index = 5'h06;
			`STSUM_OFS_SPARE:    aux_index = 5'h07;
			`STSUM_OFS_LOSMON:   aux_index = 5'h08;
			`STSUM_OFS_PPMMON:   aux_index = 5'h09;
			`STSUM_OFS_FREQMON:  aux_index = 5'h0A;
			`STSUM_OFS_OTPSTS:   aux_index = 5'h0B;
			`STSUM_OFS_OTPERR:   aux_index = 5'h0C;
			`STSUM_OFS_OTPPAR:   aux_index = 5'h0D;
			`STSUM_OFS_DPOST:    aux_index = 5'h0E;
			`STSUM_OFS_APOST:    aux_index = 5'h0F;
			`STSUM_OFS_DPOSTFSM: aux_index = 5'h10;
			`STSUM_OFS_APOSTFSM: aux_index = 5'h11;
			default:             aux_index = 5'h1F;
		endcase
	endfunction : aux_index

	// field width of each wider status register, unused bits read zero
	function automatic logic [31:0] aux_mask(input int idx);
		case (idx)
			0:              aux_mask = `STSUM_MASK_24;
			1, 4, 5, 8, 9:  aux_mask = `STSUM_MASK_8;
			11, 12:         aux_mask = `STSUM_MASK_8;
			10, 14, 15:     aux_mask = `STSUM_MASK_32;
			default:        aux_mask = `STSUM_MASK_16;
		endcase
	endfunction : aux_mask

	genvar gi;
	generate
		for (gi = 0; gi < `STSUM_AUX_COUNT; gi = gi + 1) begin : g_aux
			assign aux_masked[gi] = aux_status_in[gi] & aux_mask(gi);
		end
	endgenerate

	stsum_gate u_int_gate (
		.clk_sys_in   (clk_sys_in),
		.reset_n_in   (reset_n_in),
		.event_in     (event_in),
		.enable_in    (int_en_in),
		.global_en_in (int_global_en_in),
		.summary_out  (int_summary)
	);

	stsum_gate u_fault_gate (
		.clk_sys_in   (clk_sys_in),
		.reset_n_in   (reset_n_in),
		.event_in     (event_in),
		.enable_in    (fault_en_in),
		.global_en_in (fault_global_en_in),
		.summary_out  (fault_summary)
	);

	// pin mux assignment is made outside; these are the pin sources
	assign gpio_int_out   = int_summary;
	assign gpio_fault_out = fault_summary;
	assign safe_state_out = fault_summary;

	assign dev_word = {6'h00,
		int_summary,
		fault_summary,
		dev_misc_in[23:19],
		boot_done,
		dev_misc_in[17:8],
		device_ready,
		dev_misc_in[6:0]};

	assign sel     = decode_sel(addr_in);
	assign aux_idx = aux_index(addr_in);

	assign next_rdata =
		(sel == stsum_pkg::STSUM_SEL_SIG)      ? sig_result :
		(sel == stsum_pkg::STSUM_SEL_DEV)      ? dev_word :
		(sel == stsum_pkg::STSUM_SEL_AUX)      ? aux_masked[aux_idx] :
		(sel == stsum_pkg::STSUM_SEL_IRQ_STAT) ? {27'h0000000, irq_stat} :
		(sel == stsum_pkg::STSUM_SEL_IRQ_MASK) ? {27'h0000000, irq_mask} :
		32'h00000000;

	// only the mask takes writes; every status field ignores them
	assign wr_irq_mask = wr_in && (sel == stsum_pkg::STSUM_SEL_IRQ_MASK);
	assign rd_irq_stat = rd_in && (sel == stsum_pkg::STSUM_SEL_IRQ_STAT);

	assign irq_events[`STSUM_IRQ_SIG]   = sig_check_done_in;
	assign irq_events[`STSUM_IRQ_BOOT]  = boot_done_in;
	assign irq_events[`STSUM_IRQ_READY] = otp_load_done_in;
	assign irq_events[`STSUM_IRQ_INT]   = int_summary & ~int_prev;
	assign irq_events[`STSUM_IRQ_FAULT] = fault_summary & ~fault_prev;

	// read clears, but an event in the clearing cycle still lands
	assign next_irq_stat = (rd_irq_stat ? `STSUM_IRQ_RESET : irq_stat)
		| irq_events;

	assign irq_out = |(irq_stat & irq_mask);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= 32'h00000000;
		end else if (rd_in) begin
			rdata_out <= next_rdata;
		end else begin
			rdata_out <= 32'h00000000;
		end
	end

	// the crc is only loaded by the checker, never by the bus
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sig_result <= `STSUM_SIG_RESET;
		end else if (sig_check_done_in) begin
			sig_result <= sig_crc_in;
		end
	end

	// completion flags stay set until the next device reset
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			boot_done    <= 1'b0;
			device_ready <= 1'b0;
		end else begin
			boot_done    <= boot_done | boot_done_in;
			device_ready <= device_ready | otp_load_done_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_stat   <= `STSUM_IRQ_RESET;
			irq_mask   <= `STSUM_IRQ_RESET;
			int_prev   <= 1'b0;
			fault_prev <= 1'b0;
		end else begin
			irq_stat   <= next_irq_stat;
			int_prev   <= int_summary;
			fault_prev <= fault_summary;
			if (wr_irq_mask) begin
				irq_mask <= wdata_in[`STSUM_IRQ_W-1:0];
			end
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	wire int_cause;
	wire fault_cause;
	wire rd_dev;
	wire rd_sig;
	wire wr_sig;
	wire rd_none;
	wire [`STSUM_IRQ_W-1:0] wdata_irq;
	assign int_cause   = int_global_en_in && |(event_in & int_en_in);
	assign fault_cause = fault_global_en_in && |(event_in & fault_en_in);
	assign rd_dev = rd_in && (addr_in == `STSUM_BASE + `STSUM_OFS_DEV);
	assign rd_sig = rd_in && (addr_in == `STSUM_BASE + `STSUM_OFS_SIG);
	assign wr_sig = wr_in && (addr_in == `STSUM_BASE + `STSUM_OFS_SIG);
	assign rd_none = rd_in && (sel == stsum_pkg::STSUM_SEL_NONE);
	assign wdata_irq = wdata_in[`STSUM_IRQ_W-1:0];

	a_dev_int_read: assert property (
		rd_dev |=> rdata_out[`STSUM_DEV_INT_BIT] == $past(int_summary))
		else $error("device word does not show interrupt summary");

	a_sig_read: assert property (
		rd_sig |=> rdata_out == $past(sig_result))
		else $error("signature word read returned wrong value");

	a_sig_capture: assert property (
		sig_check_done_in |=> sig_result == $past(sig_crc_in))
		else $error("crc result not captured on check completion");

	a_int_or: assert property (
		int_cause |=> int_summary)
		else $error("interrupt summary missed an enabled event");

	a_int_gate: assert property (
		!int_global_en_in |=> !int_summary && !gpio_int_out)
		else $error("interrupt summary set with global enable off");

	a_int_pin: assert property (
		!int_cause ##1 int_cause |=> gpio_int_out)
		else $error("interrupt pin did not follow new cause");

	a_fault_or: assert property (
		fault_cause |=> fault_summary)
		else $error("fault summary missed an enabled event");

	a_fault_gate: assert property (
		!fault_global_en_in |=> !fault_summary)
		else $error("fault summary set with global enable off");

	a_fault_safe: assert property (
		fault_cause |=> safe_state_out && gpio_fault_out)
		else $error("fault did not drive safe state and pin");

	a_rsv_zero: assert property (
		rd_dev |=> rdata_out[31:26] == 6'h00)
		else $error("reserved device bits not zero");

	a_boot_sticky: assert property (
		boot_done_in |=> boot_done [*4])
		else $error("boot complete flag did not stay set");

	a_ready_set: assert property (
		otp_load_done_in |=> device_ready)
		else $error("device ready not set after otp load");

	a_ro_write: assert property (
		wr_sig && !sig_check_done_in |=> $stable(sig_result))
		else $error("write changed read only signature");

	a_irq_clear: assert property (
		rd_irq_stat && irq_events == 5'h00 |=> irq_stat == 5'h00)
		else $error("irq status not cleared by read");

	// bus framing and the own irq registers sit outside the numbered rules
	a_rdata_idle: assert property (
		!rd_in |=> rdata_out == 32'h00000000)
		else $error("read data not zero outside read cycle");

	a_unmapped_zero: assert property (
		rd_none |=> rdata_out == 32'h00000000)
		else $error("unmapped read returned nonzero data");

	a_set_wins: assert property (
		rd_irq_stat |=> irq_stat == $past(irq_events))
		else $error("irq event lost in clearing read");

	a_mask_write: assert property (
		wr_irq_mask |=> irq_mask == $past(wdata_irq))
		else $error("irq mask write not taken");

	a_int_quiet: assert property (
		!int_cause |=> !int_summary)
		else $error("interrupt summary set without enabled event");

	a_fault_quiet: assert property (
		!fault_cause |=> !fault_summary)
		else $error("fault summary set without enabled event");

	a_fault_pin_off: assert property (
		!fault_global_en_in |=> !gpio_fault_out && !safe_state_out)
		else $error("fault outputs set with global enable off");

	a_ready_sticky: assert property (
		device_ready |=> device_ready)
		else $error("device ready flag dropped");

	a_sig_hold: assert property (
		!sig_check_done_in |=> $stable(sig_result))
		else $error("signature changed without a check");

	c_int_rise:   cover property (!int_summary ##1 int_summary);
	c_fault_safe: cover property (fault_cause ##1 safe_state_out);
	c_sig_read:   cover property (sig_check_done_in ##[1:4] rd_sig);
	c_irq_out:    cover property (irq_out ##[1:8] rd_irq_stat);
	c_set_wins:   cover property (rd_irq_stat && irq_events != 5'h00);
endmodule : stsum_regs

// ### tb/tb_top.sv
// Purpose: self-checking bench of the status summary registers
// Assumes: read data stand only in the cycle after the read strobe
// Notes: random stimulus from a fixed seed, corner cases mixed in
`timescale 1ns/1ns
`include "stsum_defines.svh"
module tb_top;
	logic                     clk_sys_in;
	logic                     reset_n_in;
	logic [`STSUM_ADDR_W-1:0] addr_in;
	logic [31:0]              wdata_in;
	logic                     wr_in;
	logic                     rd_in;
	logic [31:0]              rdata_out;
	logic                     sig_check_done_in;
	logic [31:0]              sig_crc_in;
	logic [31:0]              event_in;
	logic [31:0]              int_en_in;
	logic [31:0]              fault_en_in;
	logic                     int_global_en_in;
	logic                     fault_global_en_in;
	logic                     boot_done_in;
	logic                     otp_load_done_in;
	logic [23:0]              dev_misc_in;
	logic [31:0]              aux_in [`STSUM_AUX_COUNT];
	logic                     gpio_int_out;
	logic                     gpio_fault_out;
	logic                     safe_state_out;
	logic                     irq_out;
	int                       error_cnt;
	int                       total_checks;
	logic [31:0]              rv;
	logic [31:0]              crc;
	logic [31:0]              ev;
	logic [31:0]              im;
	logic [31:0]              fm;
	logic                     gi;
	logic                     gf;
	logic                     ie;
	logic                     fe;
	logic                     boot_exp;
	logic                     ready_exp;
	logic                     ip;
	logic                     fp;
	logic                     ir;
	logic                     fr;
	int aux_w [`STSUM_AUX_COUNT] = '{24, 8, 16, 16, 8, 8, 16, 16, 8, 8, 32,
		8, 8, 16, 32, 32, 16, 16};
	logic [11:0] aux_ofs [`STSUM_AUX_COUNT] = '{12'h008, 12'h00B, 12'h00C,
		12'h00E, 12'h010, 12'h011, 12'h012, 12'h014, 12'h016, 12'h017,
		12'h018, 12'h01C, 12'h01D, 12'h01E, 12'h020, 12'h024, 12'h028,
		12'h02A};

	stsum_regs dut (
		.clk_sys_in         (clk_sys_in),
		.reset_n_in         (reset_n_in),
		.addr_in            (addr_in),
		.wdata_in           (wdata_in),
		.wr_in              (wr_in),
		.rd_in              (rd_in),
		.rdata_out          (rdata_out),
		.sig_check_done_in  (sig_check_done_in),
		.sig_crc_in         (sig_crc_in),
		.event_in           (event_in),
		.int_en_in          (int_en_in),
		.fault_en_in        (fault_en_in),
		.int_global_en_in   (int_global_en_in),
		.fault_global_en_in (fault_global_en_in),
		.boot_done_in       (boot_done_in),
		.otp_load_done_in   (otp_load_done_in),
		.dev_misc_in        (dev_misc_in),
		.aux_status_in      (aux_in),
		.gpio_int_out       (gpio_int_out),
		.gpio_fault_out     (gpio_fault_out),
		.safe_state_out     (safe_state_out),
		.irq_out            (irq_out)
	);

	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	// bits 18 and 7 come from the sticky flags, never from dev_misc_in
	function automatic logic [31:0] dev_exp(input logic i, input logic f);
		return {6'h00, i, f, dev_misc_in[23:19], boot_exp, dev_misc_in[17:8],
			ready_exp, dev_misc_in[6:0]};
	endfunction : dev_exp

	function automatic logic [31:0] wmask(input int w);
		return (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
	endfunction : wmask

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic do_reset();
		reset_n_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		boot_exp  = 1'b0;
		ready_exp = 1'b0;
	endtask : do_reset

	// hang guard: the whole run must finish well inside this bound
	initial begin
		repeat (100000) @(posedge clk_sys_in);
		error_cnt++;
		summarize();
	end

	initial begin
		error_cnt = 0;
		total_checks = 0;
		reset_n_in = 1'b0;
		{addr_in, wdata_in, wr_in, rd_in, sig_check_done_in} = '0;
		{sig_crc_in, event_in, int_en_in, fault_en_in} = '0;
		{int_global_en_in, fault_global_en_in} = 2'b00;
		{boot_done_in, otp_load_done_in} = 2'b00;
		void'($urandom(32'h8c81));
		dev_misc_in = 24'($urandom);
		foreach (aux_in[k]) aux_in[k] = $urandom;
		do_reset();
		rd(`STSUM_BASE + `STSUM_OFS_SIG, rv);
		chk("sig reset", rv, `STSUM_SIG_RESET);
		rd(`STSUM_BASE + `STSUM_OFS_DEV, rv);
		chk("dev reset", rv, dev_exp(1'b0, 1'b0));
		foreach (aux_ofs[k]) begin
			rd(`STSUM_BASE + aux_ofs[k], rv);
			chk("aux reg", rv, aux_in[k] & wmask(aux_w[k]));
		end
		rd(12'h2FC, rv);
		chk("unmapped", rv, 32'h00000000);
		rd(12'h281, rv);
		chk("misaligned", rv, 32'h00000000);
		for (int k = 0; k < 2; k++) begin
			crc = (k == 0) ? 32'hFFFFFFFF : $urandom;
			@(posedge clk_sys_in);
			sig_check_done_in <= 1'b1;
			sig_crc_in        <= crc;
			@(posedge clk_sys_in);
			sig_check_done_in <= 1'b0;
			sig_crc_in        <= ~crc;
			rd(`STSUM_BASE + `STSUM_OFS_SIG, rv);
			chk("sig value", rv, crc);
			wr(`STSUM_BASE + `STSUM_OFS_SIG, ~crc);
			wr(`STSUM_BASE + `STSUM_OFS_DEV, 32'hFFFFFFFF);
			rd(`STSUM_BASE + `STSUM_OFS_SIG, rv);
			chk("sig after write", rv, crc);
		end
		{ip, fp, ir, fr} = 4'h0;
		for (int i = 0; i < 40; i++) begin
			ev = (i == 0) ? 32'hFFFFFFFF : ($urandom & $urandom);
			im = $urandom & $urandom & $urandom;
			fm = $urandom & $urandom & $urandom;
			gi = (i % 4 != 1);
			gf = (i % 4 != 2);
			@(posedge clk_sys_in);
			event_in           <= ev;
			int_en_in          <= im;
			fault_en_in        <= fm;
			int_global_en_in   <= gi;
			fault_global_en_in <= gf;
			dev_misc_in        <= 24'($urandom);
			repeat (2) @(posedge clk_sys_in);
			#1;
			ie = (|(ev & im)) & gi;
			fe = (|(ev & fm)) & gf;
			// a summary rise between steps must leave its status bit set
			ir = ir | (ie & ~ip);
			fr = fr | (fe & ~fp);
			ip = ie;
			fp = fe;
			chk("int pin", gpio_int_out, ie);
			chk("fault pin", gpio_fault_out, fe);
			chk("safe state", safe_state_out, fe);
			rd(`STSUM_BASE + `STSUM_OFS_DEV, rv);
			chk("dev word", rv, dev_exp(ie, fe));
		end
		@(posedge clk_sys_in);
		event_in <= 32'h00000000;
		repeat (3) @(posedge clk_sys_in);
		rd(`STSUM_BASE + `STSUM_OFS_IRQ_STAT, rv);
		chk("irq edges", rv, {27'h0, fr, ir, 3'b001});
		wr(`STSUM_BASE + `STSUM_OFS_IRQ_MASK, 32'h0000001F);
		@(posedge clk_sys_in);
		sig_check_done_in <= 1'b1;
		@(posedge clk_sys_in);
		sig_check_done_in <= 1'b0;
		@(posedge clk_sys_in);
		#1 chk("irq raised", irq_out, 1'b1);
		rd(`STSUM_BASE + `STSUM_OFS_IRQ_STAT, rv);
		chk("irq status", rv, 32'h00000001);
		chk("irq cleared", irq_out, 1'b0);
		// clearing read and a new event in one cycle: the event survives
		@(posedge clk_sys_in);
		addr_in           <= `STSUM_BASE + `STSUM_OFS_IRQ_STAT;
		rd_in             <= 1'b1;
		sig_check_done_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in             <= 1'b0;
		sig_check_done_in <= 1'b0;
		#1 chk("set wins data", rdata_out, 32'h00000000);
		chk("set wins line", irq_out, 1'b1);
		rd(`STSUM_BASE + `STSUM_OFS_IRQ_STAT, rv);
		chk("set wins status", rv, 32'h00000001);
		// masked events must stay sticky but keep the line low
		wr(`STSUM_BASE + `STSUM_OFS_IRQ_MASK, 32'h00000000);
		@(posedge clk_sys_in);
		boot_done_in     <= 1'b1;
		otp_load_done_in <= 1'b1;
		@(posedge clk_sys_in);
		boot_done_in     <= 1'b0;
		otp_load_done_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1 chk("irq masked", irq_out, 1'b0);
		boot_exp  = 1'b1;
		ready_exp = 1'b1;
		rd(`STSUM_BASE + `STSUM_OFS_DEV, rv);
		chk("boot flags", rv, dev_exp(1'b0, 1'b0));
		rd(`STSUM_BASE + `STSUM_OFS_IRQ_STAT, rv);
		chk("boot status", rv, 32'h00000006);
		do_reset();
		rd(`STSUM_BASE + `STSUM_OFS_SIG, rv);
		chk("sig rereset", rv, `STSUM_SIG_RESET);
		rd(`STSUM_BASE + `STSUM_OFS_DEV, rv);
		chk("dev rereset", rv, dev_exp(1'b0, 1'b0));
		summarize();
	end
endmodule : tb_top
